// File: clk_init_pkg.sv
package clk_init_pkg;

   // ==========================================================
   // Device-side port widths and wait timer width
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int TIMER_W = 32;

   // ==========================================================
   // Register offsets in the device's register window
   localparam logic [7:0] REGULATOR_CONTROL_REG = 8'h00;
   localparam logic [7:0] SUB_OSC_CONTROL = 8'h04;
   localparam logic [7:0] SUB_DRIVE_CONTROL = 8'h08;
   localparam logic [7:0] SUB_OSC_WAIT_CONTROL = 8'h0C;
   localparam logic [7:0] MAIN_DRIVE_CONTROL = 8'h10;
   localparam logic [7:0] MAIN_OSC_WAIT_CONTROL = 8'h14;
   localparam logic [7:0] MAIN_OSC_CONTROL = 8'h18;
   localparam logic [7:0] PLL_CONTROL = 8'h1C;
   localparam logic [7:0] PLL_WAIT_CONTROL = 8'h20;
   localparam logic [7:0] PLL_OSC_CONTROL = 8'h24;
   localparam logic [7:0] PLL_POWER_CONTROL = 8'h28;
   localparam logic [7:0] FAST_FREQ_CONTROL = 8'h2C;
   localparam logic [7:0] FAST_OSC_WAIT_CONTROL = 8'h30;
   localparam logic [7:0] FAST_OSC_CONTROL = 8'h34;
   localparam logic [7:0] FAST_POWER_CONTROL = 8'h38;
   localparam logic [7:0] POWER_MODE_CONTROL = 8'h3C;
   localparam logic [7:0] DIVIDER_CONTROL = 8'h40;
   localparam logic [7:0] SYS_SOURCE_CONTROL = 8'h44;

   // ==========================================================
   // Written values
   localparam logic [31:0] REGULATOR_PRESET = 32'h0000_0000;
   localparam logic [31:0] OSC_RUN = 32'h0000_0000;
   localparam logic [31:0] OSC_STOP = 32'h0000_0001;
   localparam logic [31:0] POWER_OFF = 32'h0000_0001;
   localparam int MAIN_WAIT_W = 5;
   localparam logic [4:0] MAIN_WAIT_REF = 5'h0D;
   localparam logic [3:0] DIV_BY_2 = 4'h1;
   localparam logic [3:0] DIV_BY_4 = 4'h2;

   // ==========================================================
   // Software stabilization waits, ns, and their cycle counts
   localparam longint MCLK_PERIOD_NS = 40;
   localparam longint MAIN_SOFT_WAIT_NS = 13107200;
   localparam longint SUB_SOFT_WAIT_NS = 64'h0000_0000_EE6B_2800;
   localparam longint PLL_SOFT_WAIT_NS = 1500000;
   localparam longint FAST_SOFT_WAIT_NS = 350000;
   localparam longint MAIN_SOFT_WAIT_CYC = (MAIN_SOFT_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam longint SUB_SOFT_WAIT_CYC = (SUB_SOFT_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam longint PLL_SOFT_WAIT_CYC = (PLL_SOFT_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam longint FAST_SOFT_WAIT_CYC = (FAST_SOFT_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {CHIP_A, CHIP_B, CHIP_C} chip_ver_t;
   typedef enum logic [1:0] {SRC_FAST_OSC, SRC_SUB, SRC_MAIN, SRC_PLL} sys_src_t;

   typedef struct packed {
      logic [3:0] core;
      logic [3:0] fast_periph;
      logic [3:0] slow_periph;
      logic [3:0] bus;
      logic [3:0] flash;
   } divider_t;

   localparam divider_t DIV_REF = '{DIV_BY_2, DIV_BY_2, DIV_BY_4, DIV_BY_4, DIV_BY_4};

   typedef struct packed {
      logic use_sub;
      logic use_main;
      logic use_pll;
      logic use_fast;
      chip_ver_t chip;
      logic [7:0] sub_drive;
      logic [7:0] sub_wait;
      logic [7:0] main_drive;
      logic [4:0] main_wait;
      logic [15:0] pll_ctrl;
      logic [7:0] pll_wait;
      logic [7:0] fast_freq;
      logic [7:0] fast_wait;
      logic [7:0] power_mode;
      divider_t div;
      sys_src_t src;
   } cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } wr_t;

   typedef enum logic [4:0] {
      ST_IDLE, ST_VR, ST_SUB_INIT, ST_SUB_DRIVE, ST_SUB_WAITREG, ST_SUB_EN, ST_SUB_SW_WAIT,
      ST_MAIN_DRIVE, ST_MAIN_WAITREG, ST_MAIN_EN, ST_MAIN_SW_WAIT,
      ST_PLL_CTRL, ST_PLL_WAITREG, ST_PLL_EN, ST_PLL_SW_WAIT, ST_PLL_OFF,
      ST_FAST_FREQ, ST_FAST_WAITREG, ST_FAST_EN, ST_FAST_SW_WAIT, ST_FAST_OFF,
      ST_POWER_MODE, ST_DIVIDERS, ST_SWITCH
   } st_t;

endpackage : clk_init_pkg

// File: reg_write_port.sv
`timescale 1ns/10ps
module reg_write_port
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Request from sequencer
   input wire logic req,
   input wire clk_init_pkg::wr_t cmd,
   output logic done,
   // Device register port
   output logic [7:0] dev_addr,
   output logic [31:0] dev_wdata,
   output logic dev_wr,
   input wire logic dev_ack
);

   logic [7:0] next_dev_addr;
   logic [31:0] next_dev_wdata;
   logic next_dev_wr;
   logic next_done;

   // ==========================================================
   // Hold a write until the device acknowledges it
   always_comb
   begin
      next_dev_addr = dev_addr;
      next_dev_wdata = dev_wdata;
      next_dev_wr = dev_wr;
      next_done = 1'b0;
      if (dev_wr)
      begin
         if (dev_ack)
         begin
            next_dev_wr = 1'b0;
            next_done = 1'b1;
         end
      end
      else if (req)
      begin
         next_dev_addr = cmd.addr;
         next_dev_wdata = cmd.data;
         next_dev_wr = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dev_addr <= 8'h00;
         dev_wdata <= 32'h0000_0000;
         dev_wr <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         dev_addr <= next_dev_addr;
         dev_wdata <= next_dev_wdata;
         dev_wr <= next_dev_wr;
         done <= next_done;
      end
   end

endmodule : reg_write_port

// File: wait_timer.sv
`timescale 1ns/10ps
module wait_timer
#(
   parameter int W = 32
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Control
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic done
);

   logic [W-1:0] cnt;
   logic run;
   logic [W-1:0] next_cnt;
   logic next_run;
   logic next_done;

   // ==========================================================
   // Count down a loaded number of cycles, pulse at the end
   always_comb
   begin
      next_cnt = cnt;
      next_run = run;
      next_done = 1'b0;
      if (start)
      begin
         next_cnt = load;
         next_run = 1'b1;
      end
      else if (run)
      begin
         if (cnt <= {{(W-1){1'b0}}, 1'b1})
         begin
            next_run = 1'b0;
            next_done = 1'b1;
         end
         else
         begin
            next_cnt = cnt - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Registers
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt <= '0;
         run <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         run <= next_run;
         done <= next_done;
      end
   end

endmodule : wait_timer

// File: clock_init_sequence.sv
`timescale 1ns/10ps
module clock_init_sequence
#(
   parameter logic [31:0] MAIN_WAIT_CYC = 32'(clk_init_pkg::MAIN_SOFT_WAIT_CYC),
   parameter logic [31:0] SUB_WAIT_CYC = 32'(clk_init_pkg::SUB_SOFT_WAIT_CYC),
   parameter logic [31:0] PLL_WAIT_CYC = 32'(clk_init_pkg::PLL_SOFT_WAIT_CYC),
   parameter logic [31:0] FAST_WAIT_CYC = 32'(clk_init_pkg::FAST_SOFT_WAIT_CYC)
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // User command
   input wire logic start,
   input wire clk_init_pkg::cfg_t cfg,
   // User status
   output logic busy,
   output logic done,
   output logic err,
   // Device register port
   output logic [7:0] dev_addr,
   output logic [31:0] dev_wdata,
   output logic dev_wr,
   input wire logic dev_ack
);

   clk_init_pkg::st_t st;
   clk_init_pkg::st_t next_st;
   clk_init_pkg::cfg_t cfg_q;
   clk_init_pkg::cfg_t next_cfg_q;
   clk_init_pkg::wr_t cmd;
   clk_init_pkg::wr_t next_cmd;
   logic wr_req;
   logic next_wr_req;
   logic wr_pend;
   logic next_wr_pend;
   logic wr_done;
   logic tm_start;
   logic next_tm_start;
   logic [31:0] tm_load;
   logic [31:0] next_tm_load;
   logic tm_pend;
   logic next_tm_pend;
   logic tm_done;
   logic next_busy;
   logic next_done;
   logic next_err;

   // ==========================================================
   // Step selection helpers
   function automatic clk_init_pkg::st_t fast_entry(input clk_init_pkg::cfg_t c);
      fast_entry = c.use_fast ? clk_init_pkg::ST_FAST_FREQ : clk_init_pkg::ST_FAST_OFF;
   endfunction : fast_entry

   function automatic clk_init_pkg::st_t pll_entry(input clk_init_pkg::cfg_t c);
      if (c.use_pll)
         pll_entry = clk_init_pkg::ST_PLL_CTRL;
      else if (c.chip == clk_init_pkg::CHIP_B)
         pll_entry = clk_init_pkg::ST_PLL_OFF;
      else
         pll_entry = fast_entry(c);
   endfunction : pll_entry

   function automatic clk_init_pkg::st_t main_entry(input clk_init_pkg::cfg_t c);
      main_entry = c.use_main ? clk_init_pkg::ST_MAIN_DRIVE : pll_entry(c);
   endfunction : main_entry

   // Successor of a finished step
   function automatic clk_init_pkg::st_t succ(input clk_init_pkg::st_t s,
                                              input clk_init_pkg::cfg_t c);
      case (s)
         clk_init_pkg::ST_VR: succ = clk_init_pkg::ST_SUB_INIT;
         clk_init_pkg::ST_SUB_INIT: succ = c.use_sub ? clk_init_pkg::ST_SUB_DRIVE : main_entry(c);
         clk_init_pkg::ST_SUB_DRIVE: succ = clk_init_pkg::ST_SUB_WAITREG;
         clk_init_pkg::ST_SUB_WAITREG: succ = clk_init_pkg::ST_SUB_EN;
         clk_init_pkg::ST_SUB_EN: succ = clk_init_pkg::ST_SUB_SW_WAIT;
         clk_init_pkg::ST_SUB_SW_WAIT: succ = main_entry(c);
         clk_init_pkg::ST_MAIN_DRIVE: succ = clk_init_pkg::ST_MAIN_WAITREG;
         clk_init_pkg::ST_MAIN_WAITREG: succ = clk_init_pkg::ST_MAIN_EN;
         clk_init_pkg::ST_MAIN_EN: succ = clk_init_pkg::ST_MAIN_SW_WAIT;
         clk_init_pkg::ST_MAIN_SW_WAIT: succ = pll_entry(c);
         clk_init_pkg::ST_PLL_CTRL: succ = clk_init_pkg::ST_PLL_WAITREG;
         clk_init_pkg::ST_PLL_WAITREG: succ = clk_init_pkg::ST_PLL_EN;
         clk_init_pkg::ST_PLL_EN: succ = clk_init_pkg::ST_PLL_SW_WAIT;
         clk_init_pkg::ST_PLL_SW_WAIT: succ = fast_entry(c);
         clk_init_pkg::ST_PLL_OFF: succ = fast_entry(c);
         clk_init_pkg::ST_FAST_FREQ: succ = clk_init_pkg::ST_FAST_WAITREG;
         clk_init_pkg::ST_FAST_WAITREG: succ = clk_init_pkg::ST_FAST_EN;
         clk_init_pkg::ST_FAST_EN: succ = clk_init_pkg::ST_FAST_SW_WAIT;
         clk_init_pkg::ST_FAST_SW_WAIT: succ = clk_init_pkg::ST_POWER_MODE;
         clk_init_pkg::ST_FAST_OFF: succ = clk_init_pkg::ST_POWER_MODE;
         clk_init_pkg::ST_POWER_MODE: succ = clk_init_pkg::ST_DIVIDERS;
         clk_init_pkg::ST_DIVIDERS: succ = clk_init_pkg::ST_SWITCH;
         default: succ = clk_init_pkg::ST_IDLE;
      endcase
   endfunction : succ

   // Software wait length of a step, zero for write steps
   function automatic logic [31:0] wait_of(input clk_init_pkg::st_t s);
      case (s)
         clk_init_pkg::ST_SUB_SW_WAIT: wait_of = SUB_WAIT_CYC;
         clk_init_pkg::ST_MAIN_SW_WAIT: wait_of = MAIN_WAIT_CYC;
         clk_init_pkg::ST_PLL_SW_WAIT: wait_of = PLL_WAIT_CYC;
         clk_init_pkg::ST_FAST_SW_WAIT: wait_of = FAST_WAIT_CYC;
         default: wait_of = 32'h0000_0000;
      endcase
   endfunction : wait_of

   // Register write belonging to a step
   function automatic clk_init_pkg::wr_t wr_of(input clk_init_pkg::st_t s,
                                               input clk_init_pkg::cfg_t c);
      wr_of.addr = 8'h00;
      wr_of.data = 32'h0000_0000;
      case (s)
         clk_init_pkg::ST_VR:
            wr_of = '{clk_init_pkg::REGULATOR_CONTROL_REG, clk_init_pkg::REGULATOR_PRESET};
         clk_init_pkg::ST_SUB_INIT:
            wr_of = '{clk_init_pkg::SUB_OSC_CONTROL, clk_init_pkg::OSC_STOP};
         clk_init_pkg::ST_SUB_DRIVE:
            wr_of = '{clk_init_pkg::SUB_DRIVE_CONTROL, {24'h000000, c.sub_drive}};
         clk_init_pkg::ST_SUB_WAITREG:
            wr_of = '{clk_init_pkg::SUB_OSC_WAIT_CONTROL, {24'h000000, c.sub_wait}};
         clk_init_pkg::ST_SUB_EN:
            wr_of = '{clk_init_pkg::SUB_OSC_CONTROL, clk_init_pkg::OSC_RUN};
         clk_init_pkg::ST_MAIN_DRIVE:
            wr_of = '{clk_init_pkg::MAIN_DRIVE_CONTROL, {24'h000000, c.main_drive}};
         clk_init_pkg::ST_MAIN_WAITREG:
            wr_of = '{clk_init_pkg::MAIN_OSC_WAIT_CONTROL, {27'h0, c.main_wait}};
         clk_init_pkg::ST_MAIN_EN:
            wr_of = '{clk_init_pkg::MAIN_OSC_CONTROL, clk_init_pkg::OSC_RUN};
         clk_init_pkg::ST_PLL_CTRL:
            wr_of = '{clk_init_pkg::PLL_CONTROL, {16'h0000, c.pll_ctrl}};
         clk_init_pkg::ST_PLL_WAITREG:
            wr_of = '{clk_init_pkg::PLL_WAIT_CONTROL, {24'h000000, c.pll_wait}};
         clk_init_pkg::ST_PLL_EN:
            wr_of = '{clk_init_pkg::PLL_OSC_CONTROL, clk_init_pkg::OSC_RUN};
         clk_init_pkg::ST_PLL_OFF:
            wr_of = '{clk_init_pkg::PLL_POWER_CONTROL, clk_init_pkg::POWER_OFF};
         clk_init_pkg::ST_FAST_FREQ:
            wr_of = '{clk_init_pkg::FAST_FREQ_CONTROL, {24'h000000, c.fast_freq}};
         clk_init_pkg::ST_FAST_WAITREG:
            wr_of = '{clk_init_pkg::FAST_OSC_WAIT_CONTROL, {24'h000000, c.fast_wait}};
         clk_init_pkg::ST_FAST_EN:
            wr_of = '{clk_init_pkg::FAST_OSC_CONTROL, clk_init_pkg::OSC_RUN};
         clk_init_pkg::ST_FAST_OFF:
            wr_of = '{clk_init_pkg::FAST_POWER_CONTROL, clk_init_pkg::POWER_OFF};
         clk_init_pkg::ST_POWER_MODE:
            wr_of = '{clk_init_pkg::POWER_MODE_CONTROL, {24'h000000, c.power_mode}};
         clk_init_pkg::ST_DIVIDERS:
            wr_of = '{clk_init_pkg::DIVIDER_CONTROL, {12'h000, c.div}};
         clk_init_pkg::ST_SWITCH:
            wr_of = '{clk_init_pkg::SYS_SOURCE_CONTROL, {30'h0, c.src}};
         default:
            wr_of = '{8'h00, 32'h0000_0000};
      endcase
   endfunction : wr_of

   // Requested source has been started and waited for
   function automatic logic src_ready(input clk_init_pkg::cfg_t c);
      case (c.src)
         clk_init_pkg::SRC_PLL: src_ready = c.use_pll & c.use_main;
         clk_init_pkg::SRC_MAIN: src_ready = c.use_main;
         clk_init_pkg::SRC_SUB: src_ready = c.use_sub;
         default: src_ready = c.use_fast;
      endcase
   endfunction : src_ready

   // ==========================================================
   // Sequencer next state
   always_comb
   begin
      next_st = st;
      next_cfg_q = cfg_q;
      next_cmd = cmd;
      next_wr_req = 1'b0;
      next_wr_pend = wr_pend;
      next_tm_start = 1'b0;
      next_tm_load = tm_load;
      next_tm_pend = tm_pend;
      next_busy = busy;
      next_done = done;
      next_err = err;
      case (st)
         clk_init_pkg::ST_IDLE:
         begin
            if (start)
            begin
               next_cfg_q = cfg;
               next_st = clk_init_pkg::ST_VR;
               next_busy = 1'b1;
               next_done = 1'b0;
               next_err = 1'b0;
            end
         end
         default:
         begin
            if (wait_of(st) != 32'h0000_0000)
            begin
               // Software stabilization wait
               if (!tm_pend)
               begin
                  next_tm_start = 1'b1;
                  next_tm_load = wait_of(st);
                  next_tm_pend = 1'b1;
               end
               else if (tm_done)
               begin
                  next_tm_pend = 1'b0;
                  next_st = succ(st, cfg_q);
               end
            end
            else if (st == clk_init_pkg::ST_SWITCH && !src_ready(cfg_q))
            begin
               // Source not started: refuse the switch
               next_err = 1'b1;
               next_busy = 1'b0;
               next_done = 1'b1;
               next_st = clk_init_pkg::ST_IDLE;
            end
            else if (!wr_pend)
            begin
               next_cmd = wr_of(st, cfg_q);
               next_wr_req = 1'b1;
               next_wr_pend = 1'b1;
            end
            else if (wr_done)
            begin
               next_wr_pend = 1'b0;
               next_st = succ(st, cfg_q);
               if (st == clk_init_pkg::ST_SWITCH)
               begin
                  next_busy = 1'b0;
                  next_done = 1'b1;
               end
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= clk_init_pkg::ST_IDLE;
         cfg_q <= '0;
         cmd <= '0;
         wr_req <= 1'b0;
         wr_pend <= 1'b0;
         tm_start <= 1'b0;
         tm_load <= 32'h0000_0000;
         tm_pend <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
      end
      else
      begin
         st <= next_st;
         cfg_q <= next_cfg_q;
         cmd <= next_cmd;
         wr_req <= next_wr_req;
         wr_pend <= next_wr_pend;
         tm_start <= next_tm_start;
         tm_load <= next_tm_load;
         tm_pend <= next_tm_pend;
         busy <= next_busy;
         done <= next_done;
         err <= next_err;
      end
   end

   // ==========================================================
   // Register write engine and wait timer
   reg_write_port reg_write_port_inst
   (
      .mclk(mclk),
      .rst_b(rst_b),
      .req(wr_req),
      .cmd(cmd),
      .done(wr_done),
      .dev_addr(dev_addr),
      .dev_wdata(dev_wdata),
      .dev_wr(dev_wr),
      .dev_ack(dev_ack)
   );

   wait_timer #(.W(clk_init_pkg::TIMER_W)) wait_timer_inst
   (
      .mclk(mclk),
      .rst_b(rst_b),
      .start(tm_start),
      .load(tm_load),
      .done(tm_done)
   );

endmodule : clock_init_sequence

// File: clock_init_sequence_properties.sv
`timescale 1ns/10ps
module clock_init_sequence_properties
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // User side
   input wire logic start,
   input wire clk_init_pkg::cfg_t cfg,
   input wire logic busy,
   input wire logic done,
   input wire logic err,
   // Device side
   input wire logic [7:0] dev_addr,
   input wire logic [31:0] dev_wdata,
   input wire logic dev_wr,
   input wire logic dev_ack
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Write handshake and run status
   sequence s_ack;
      dev_wr && dev_ack;
   endsequence
   sequence s_wait;
      dev_wr && !dev_ack;
   endsequence
   a_write_holds: assert property (s_wait |=> dev_wr && $stable(dev_addr) && $stable(dev_wdata))
      else $error("write dropped before ack");
   a_write_ends: assert property (s_ack |=> !dev_wr [*3])
      else $error("write not closed after ack");
   a_regulator_first: assert property ($rose(busy) |-> ##2 dev_wr && dev_addr == 8'h00 && dev_wdata == 32'h0)
      else $error("first write not regulator preset");
   a_write_in_run: assert property (dev_wr |-> busy)
      else $error("write outside a run");
   a_done_idle: assert property (done |-> !busy)
      else $error("done while busy");
   a_err_done: assert property (err |-> done)
      else $error("err without done");
   a_pll_off_b: assert property (dev_wr && dev_addr == clk_init_pkg::PLL_POWER_CONTROL |-> cfg.chip == clk_init_pkg::CHIP_B && !cfg.use_pll)
      else $error("pll power off on wrong chip");
   a_switch_src: assert property (dev_wr && dev_addr == clk_init_pkg::SYS_SOURCE_CONTROL |-> dev_wdata == {30'h0, cfg.src} && !err)
      else $error("bad source switch");
endmodule : clock_init_sequence_properties

// File: dev_model.sv
`timescale 1ns/10ps
module dev_model
#(
   parameter int HOLD = 4
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] dev_addr,
   input wire logic [31:0] dev_wdata,
   input wire logic dev_wr,
   output logic dev_ack,
   // Test controls
   input wire logic [3:0] ack_dly,
   input wire logic chip_b
);
   clk_init_pkg::wr_t log_q[$];
   longint log_t[$];
   logic [31:0] regs [0:17];
   int cnt;
   int hold_cnt;
   longint cyc;
   logic main_out;
   // ==========================================================
   // Write acceptance, logging, oscillator hold-off
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dev_ack <= 1'b0;
         cnt <= 0;
         hold_cnt <= 0;
         cyc <= 0;
         for (int k = 0; k < 18; k++) regs[k] <= clk_init_pkg::OSC_STOP;
      end
      else
      begin
         cyc <= cyc + 1;
         if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
         if (dev_wr && dev_ack)
         begin
            dev_ack <= 1'b0;
            cnt <= 0;
            log_q.push_back('{addr: dev_addr, data: dev_wdata});
            log_t.push_back(cyc);
            if (dev_addr != clk_init_pkg::PLL_POWER_CONTROL || chip_b) regs[dev_addr[6:2]] <= dev_wdata;
            if (dev_addr == clk_init_pkg::MAIN_OSC_CONTROL) hold_cnt <= HOLD;
         end
         else if (dev_wr)
         begin
            if (cnt >= int'(ack_dly)) dev_ack <= 1'b1;
            else cnt <= cnt + 1;
         end
      end
   end
   // Main clock reaches the core only after hold-off
   assign main_out = (hold_cnt == 0) && (regs[6] == clk_init_pkg::OSC_RUN);
endmodule : dev_model

// File: clock_init_sequence_bench.sv
`timescale 1ns/10ps
module clock_init_sequence_bench;
   localparam int W = 5;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   clk_init_pkg::cfg_t cfg = '0;
   logic busy, done, err, dev_wr, dev_ack, chip_b = 1'b0;
   logic [7:0] dev_addr;
   logic [31:0] dev_wdata;
   logic [3:0] ack_dly = 4'h0;
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   // ==========================================================
   // Clock, timeout
   always #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         summarize();
      end
   end
   clock_init_sequence #(.MAIN_WAIT_CYC(W), .SUB_WAIT_CYC(W), .PLL_WAIT_CYC(W),
      .FAST_WAIT_CYC(W)) clock_init_sequence_inst (.mclk(mclk), .rst_b(rst_b),
      .start(start), .cfg(cfg), .busy(busy), .done(done), .err(err), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_ack(dev_ack));
   dev_model dev_model_inst (.mclk(mclk), .rst_b(rst_b), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_ack(dev_ack), .ack_dly(ack_dly),
      .chip_b(chip_b));
   // ==========================================================
   // Compare tasks
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit
   task automatic check_wr(input clk_init_pkg::wr_t got, input clk_init_pkg::wr_t exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_wr
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   // ==========================================================
   // Expected write list from the settings
   task automatic add(inout clk_init_pkg::wr_t q[$], input logic [7:0] a, input logic [31:0] d);
      q.push_back('{addr: a, data: d});
   endtask : add
   task automatic build(input clk_init_pkg::cfg_t c, output clk_init_pkg::wr_t q[$],
      output logic ok);
      q = {};
      add(q, 8'h00, 32'h0);
      add(q, 8'h04, 32'h1);
      if (c.use_sub)
      begin
         add(q, 8'h08, {24'h0, c.sub_drive});
         add(q, 8'h0C, {24'h0, c.sub_wait});
         add(q, 8'h04, 32'h0);
      end
      if (c.use_main)
      begin
         add(q, 8'h10, {24'h0, c.main_drive});
         add(q, 8'h14, {27'h0, c.main_wait});
         add(q, 8'h18, 32'h0);
      end
      if (c.use_pll)
      begin
         add(q, 8'h1C, {16'h0, c.pll_ctrl});
         add(q, 8'h20, {24'h0, c.pll_wait});
         add(q, 8'h24, 32'h0);
      end
      else if (c.chip == clk_init_pkg::CHIP_B) add(q, 8'h28, 32'h1);
      if (c.use_fast)
      begin
         add(q, 8'h2C, {24'h0, c.fast_freq});
         add(q, 8'h30, {24'h0, c.fast_wait});
         add(q, 8'h34, 32'h0);
      end
      else add(q, 8'h38, 32'h1);
      add(q, 8'h3C, {24'h0, c.power_mode});
      add(q, 8'h40, {12'h0, c.div});
      ok = (c.src == clk_init_pkg::SRC_FAST_OSC) ? c.use_fast :
           (c.src == clk_init_pkg::SRC_SUB) ? c.use_sub :
           (c.src == clk_init_pkg::SRC_MAIN) ? c.use_main : c.use_pll && c.use_main;
      if (ok) add(q, 8'h44, {30'h0, c.src});
   endtask : build
   // ==========================================================
   // One run: start, optional ignored start, wait, compare
   task automatic run_seq(input clk_init_pkg::cfg_t c, input logic [3:0] dly, input bit again);
      clk_init_pkg::wr_t q[$];
      logic ok;
      int base;
      int n;
      base = dev_model_inst.log_q.size();
      @(posedge mclk);
      #1;
      cfg = c;
      chip_b = (c.chip == clk_init_pkg::CHIP_B);
      ack_dly = dly;
      start = 1'b1;
      @(posedge mclk);
      #1;
      start = 1'b0;
      check_bit(busy, 1'b1);
      repeat (4) @(posedge mclk);
      #1;
      if (again) start = 1'b1;
      @(posedge mclk);
      #1;
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 2000)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      build(c, q, ok);
      check_bit(done, 1'b1);
      check_bit(busy, 1'b0);
      check_bit(err, !ok);
      check_bit(dev_model_inst.log_q.size() == base + q.size(), 1'b1);
      for (int k = 0; k < q.size() && base + k < dev_model_inst.log_q.size(); k++)
      begin
         check_wr(dev_model_inst.log_q[base + k], q[k]);
         if (q[k].addr == 8'h18 && k + 1 < q.size())
            check_bit(dev_model_inst.log_t[base + k + 1] - dev_model_inst.log_t[base + k]
               >= W + 5, 1'b1);
      end
   endtask : run_seq
   // ==========================================================
   // Scenarios
   task automatic t_reference();
      clk_init_pkg::cfg_t c;
      c = '{use_sub: 0, use_main: 1, use_pll: 1, use_fast: 0, chip: clk_init_pkg::CHIP_A,
         sub_drive: 8'h00, sub_wait: 8'h00, main_drive: 8'h30, main_wait: clk_init_pkg::MAIN_WAIT_REF,
         pll_ctrl: 16'h0901, pll_wait: 8'h09, fast_freq: 8'h00, fast_wait: 8'h00,
         power_mode: 8'h00, div: clk_init_pkg::DIV_REF, src: clk_init_pkg::SRC_PLL};
      run_seq(c, 4'h0, 1'b1);
      c.use_sub = 1'b1;
      c.use_fast = 1'b1;
      c.chip = clk_init_pkg::CHIP_C;
      c.sub_drive = 8'h01;
      c.fast_freq = 8'h03;
      c.fast_wait = 8'h03;
      c.src = clk_init_pkg::SRC_SUB;
      run_seq(c, 4'h3, 1'b0);
      c.use_pll = 1'b0;
      c.chip = clk_init_pkg::CHIP_B;
      c.src = clk_init_pkg::SRC_FAST_OSC;
      run_seq(c, 4'h1, 1'b0);
      c.use_main = 1'b0;
      c.use_pll = 1'b1;
      c.src = clk_init_pkg::SRC_PLL;
      run_seq(c, 4'h0, 1'b0);
      c.use_fast = 1'b0;
      c.use_main = 1'b1;
      c.src = clk_init_pkg::SRC_MAIN;
      run_seq(c, 4'h2, 1'b0);
   endtask : t_reference
   // Reset in the middle of a write, then a clean run
   task automatic t_mid_reset();
      @(posedge mclk);
      #1;
      start = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      start = 1'b0;
      rst_b = 1'b0;
      #1;
      check_bit(busy | dev_wr | done, 1'b0);
      @(posedge mclk);
      #1;
      rst_b = 1'b1;
      run_seq(cfg, 4'h0, 1'b0);
   endtask : t_mid_reset
   initial
   begin
      repeat (12) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      t_reference();
      t_mid_reset();
      summarize();
   end
endmodule : clock_init_sequence_bench
bind clock_init_sequence clock_init_sequence_properties clock_init_sequence_properties_inst (
   .mclk(mclk), .rst_b(rst_b), .start(start), .cfg(cfg), .busy(busy), .done(done), .err(err),
   .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_ack(dev_ack));
